// ==== shared/cpu_status_regs.svh ====
/*
 Offsets, field positions, reset values and bank geometry of the core
 status register and its companion high program-counter holding latch.
 Assumes inclusion by bare name from the two design files.
*/
`ifndef CPU_STATUS_REGS_SVH
`define CPU_STATUS_REGS_SVH

// ==========================================================
// Register offsets (low seven bits, shared in every bank)
`define STATUS_OFFSET 7'h03
`define PCHI_OFFSET 7'h0a
// ==========================================================
// Field positions
`define BIT_CARRY 3'h0
`define BIT_DCARRY 3'h1
`define BIT_ZERO 3'h2
`define BIT_PDOWN 3'h3
`define BIT_TOUT 3'h4
`define BIT_RP_LO 3'h5
`define BIT_RP_HI 3'h6
`define BIT_IRP 3'h7
// ==========================================================
// Reset values: bank selects 0, flags per power-up, arithmetic flags 0
`define STATUS_RESET 8'h18
`define PCHI_RESET 5'h00
// ==========================================================
// Geometry
`define BANK_OFFSET_BITS 7
`define NIBBLE_MSB 3

`endif

// ==== shared/cpu_status_pkg.sv ====
/*
 Types for the core status register block.
 Assumes the datapath presents one destination write per cycle.
*/
package cpu_status_pkg;

	typedef struct packed {
		logic indirect_bank_select;
		logic [1:0] direct_bank_select;
		logic timeout_flag;
		logic powerdown_flag;
		logic zero_flag;
		logic digit_carry_flag;
		logic carry_flag;
	} status_t;

	typedef enum logic [3:0] {
		ALU_PASS = 4'h1,
		ALU_ADD = 4'h2,
		ALU_SUB = 4'h4,
		ALU_LOGIC = 4'h8
	} alu_op_t;

	typedef struct packed {
		logic valid;
		logic indirect;
		logic [6:0] offset;
		logic [7:0] data;
	} file_write_t;

endpackage

// ==== hdl/cpu_flag_adder.sv ====
/*
 Eight-bit flag-producing adder/subtractor.
 Assumes operands are stable within the cycle; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_regs.svh"

module cpu_flag_adder #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] a_in, // First operand
	input wire logic [WIDTH-1:0] b_in, // Second operand
	input wire logic sub_in, // High: a minus b
	output logic [WIDTH-1:0] sum_out, // Result
	output logic carry_out, // Carry out of msb, inverted borrow on sub
	output logic dcarry_out // Carry out of bit 3
);
	logic [WIDTH-1:0] b_eff;
	logic [WIDTH:0] full;
	logic [`NIBBLE_MSB+1:0] low;

	if (WIDTH < `NIBBLE_MSB + 2) begin : g_bad_width
		$error("cpu_flag_adder: WIDTH too small");
	end

	// Subtract adds two's complement, so carries read as not-borrow
	assign b_eff = sub_in ? ~b_in : b_in; // RULE_08
	assign full = {1'b0, a_in} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub_in};
	assign low = {1'b0, a_in[`NIBBLE_MSB:0]} + {1'b0, b_eff[`NIBBLE_MSB:0]}
		+ {{(`NIBBLE_MSB+1){1'b0}}, sub_in};
	assign sum_out = full[WIDTH-1:0];
	assign carry_out = full[WIDTH]; // RULE_07
	assign dcarry_out = low[`NIBBLE_MSB+1]; // RULE_14
endmodule
`default_nettype wire

// ==== hdl/cpu_status_bank_select.sv ====
/*
 Core status register with bank selects, reset-cause flags, arithmetic
 flags, high program-counter holding latch and bank address formation.
 Assumes the execution datapath drives one file write, one flag update
 and the sleep/watchdog events per cycle, synchronous to core_clk_in.
*/
//
// Overview of operation
// [RULE_01] Upper counter bits reached only through a latch copied on jumps.
// [RULE_02] Status and latch decode at the same offset in every bank.
// [RULE_03] Status accepts writes from any instruction as a destination.
// [RULE_04] Flag-updating instruction writing status: flags win over data.
// [RULE_05] Timeout and power-down flags ignore software writes.
// [RULE_06] Software should alter status with bit, swap or move instructions.
// [RULE_07] Subtract carries mean not-borrow.
// [RULE_08] Subtract adds the two's complement of the second operand.
// [RULE_09] Indirect bank bit selects 000h-0FFh or 100h-1FFh.
// [RULE_10] Two direct bank bits choose banks 0 to 3.
// [RULE_11] Banks are 128 bytes; bank bits sit above the 7-bit offset.
// [RULE_12] Power-down clears on sleep, sets on power-up or watchdog clear.
// [RULE_13] Timeout sets on power-up, watchdog clear, sleep; clears on timeout.
// [RULE_14] Zero on zero result; digit carry from bit 3; carry from msb.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_regs.svh"

module cpu_status_bank_select #(
	parameter int DATA_W = 8,
	parameter int PCHI_W = 5
) (
	input wire logic core_clk_in, // Core clock, 250 MHz
	input wire logic rst_b_in, // Power-on reset, async, active low
	input var cpu_status_pkg::file_write_t wr_in, // Destination write
	input wire logic [6:0] rd_offset_in, // Direct read offset
	input wire logic [7:0] fsr_in, // Indirect pointer
	input var cpu_status_pkg::alu_op_t alu_op_in, // Operation class
	input wire logic [7:0] alu_a_in, // ALU first operand
	input wire logic [7:0] alu_b_in, // ALU second operand
	input wire logic flag_update_in, // Instruction updates Z/DC/C
	input wire logic flag_z_only_in, // Instruction touches Z only
	input wire logic sleep_in, // Sleep instruction executes
	input wire logic wdt_clear_in, // Watchdog-clear instruction
	input wire logic wdt_timeout_in, // Watchdog time-out event
	input wire logic pc_load_in, // Jump: copy latch into high pc
	output cpu_status_pkg::status_t status_out, // Status register
	output logic [7:0] rd_data_out, // Read data of shared registers
	output logic [7:0] alu_result_out, // Registered ALU result
	output logic [8:0] direct_addr_out, // Direct data address
	output logic [8:0] indirect_addr_out, // Indirect data address
	output logic [PCHI_W-1:0] pc_high_out // Upper program-counter bits
);
	// ==========================================================
	// Parameter checks
	if (DATA_W != 8) begin : g_bad_data_w
		$error("cpu_status_bank_select: DATA_W must be 8");
	end
	if (PCHI_W != 5) begin : g_bad_pchi_w
		$error("cpu_status_bank_select: PCHI_W must be 5");
	end

	localparam logic [7:0] STATUS_RST = `STATUS_RESET;

	// ==========================================================
	// Arithmetic
	logic [7:0] sum;
	logic carry;
	logic dcarry;
	logic [7:0] next_result;
	logic next_z;

	cpu_flag_adder #(.WIDTH(8)) u_adder (
		.a_in(alu_a_in),
		.b_in(alu_b_in),
		.sub_in(alu_op_in == cpu_status_pkg::ALU_SUB),
		.sum_out(sum),
		.carry_out(carry),
		.dcarry_out(dcarry)
	);

	always_comb begin
		case (alu_op_in)
			cpu_status_pkg::ALU_ADD: next_result = sum;
			cpu_status_pkg::ALU_SUB: next_result = sum; // RULE_08
			cpu_status_pkg::ALU_LOGIC: next_result = alu_a_in & alu_b_in;
			default: next_result = alu_a_in;
		endcase
	end
	assign next_z = (next_result == 8'h00); // RULE_14

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			alu_result_out <= 8'h00;
		else
			alu_result_out <= next_result;
	end

	// ==========================================================
	// Register decode, shared in every bank
	logic [6:0] wr_off;
	logic hit_status;
	logic hit_pchi;
	assign wr_off = wr_in.indirect ? fsr_in[6:0] : wr_in.offset;
	assign hit_status = wr_in.valid && wr_off == `STATUS_OFFSET; // RULE_02
	assign hit_pchi = wr_in.valid && wr_off == `PCHI_OFFSET; // RULE_02

	// ==========================================================
	// Status register
	cpu_status_pkg::status_t st;
	assign status_out = st;

	// Bank selects: plain file-register bits
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st.indirect_bank_select <= STATUS_RST[`BIT_IRP];
			st.direct_bank_select <= STATUS_RST[`BIT_RP_HI:`BIT_RP_LO];
		end else if (hit_status) begin
			st.indirect_bank_select <= wr_in.data[`BIT_IRP]; // RULE_03
			st.direct_bank_select <=
				wr_in.data[`BIT_RP_HI:`BIT_RP_LO]; // RULE_03
		end
	end

	// Reset-cause flags never take written data
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st.timeout_flag <= STATUS_RST[`BIT_TOUT]; // RULE_13
			st.powerdown_flag <= STATUS_RST[`BIT_PDOWN]; // RULE_12
		end else begin // RULE_05
			if (wdt_timeout_in)
				st.timeout_flag <= 1'h0; // RULE_13
			else if (wdt_clear_in || sleep_in)
				st.timeout_flag <= 1'h1; // RULE_13
			if (sleep_in)
				st.powerdown_flag <= 1'h0; // RULE_12
			else if (wdt_clear_in)
				st.powerdown_flag <= 1'h1; // RULE_12
		end
	end

	// Flag logic takes precedence over a data write to the same bits
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st.zero_flag <= STATUS_RST[`BIT_ZERO];
			st.digit_carry_flag <= STATUS_RST[`BIT_DCARRY];
			st.carry_flag <= STATUS_RST[`BIT_CARRY];
		end else if (flag_update_in) begin
			// Data never reaches Z, DC or C here, even for a zero-only op
			st.zero_flag <= next_z; // RULE_04
			if (!flag_z_only_in) begin
				st.digit_carry_flag <= dcarry; // RULE_07
				st.carry_flag <= carry; // RULE_07
			end
		end else if (hit_status) begin
			st.zero_flag <= wr_in.data[`BIT_ZERO]; // RULE_03
			st.digit_carry_flag <= wr_in.data[`BIT_DCARRY]; // RULE_03
			st.carry_flag <= wr_in.data[`BIT_CARRY]; // RULE_03
		end
	end

	// ==========================================================
	// High program-counter latch
	logic [PCHI_W-1:0] pc_high_latch;
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			pc_high_latch <= `PCHI_RESET;
		else if (hit_pchi)
			pc_high_latch <= wr_in.data[PCHI_W-1:0]; // RULE_01
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			pc_high_out <= `PCHI_RESET;
		else if (pc_load_in)
			pc_high_out <= pc_high_latch; // RULE_01
	end

	// ==========================================================
	// Read data and address formation
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			rd_data_out <= 8'h00;
		else if (rd_offset_in == `STATUS_OFFSET)
			rd_data_out <= st; // RULE_02
		else if (rd_offset_in == `PCHI_OFFSET)
			rd_data_out <= {3'h0, pc_high_latch};
		else
			rd_data_out <= 8'h00;
	end

	// Addresses use the value stored before this edge
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			direct_addr_out <= 9'h000;
			indirect_addr_out <= 9'h000;
		end else begin
			direct_addr_out <= {st.direct_bank_select,
				rd_offset_in}; // RULE_10 RULE_11
			indirect_addr_out <= {st.indirect_bank_select,
				fsr_in}; // RULE_09
		end
	end

	// ==========================================================
	// Assertions
	a_sw_no_tout: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		hit_status && !wdt_timeout_in && !wdt_clear_in && !sleep_in
		|=> $stable(st.timeout_flag) && $stable(st.powerdown_flag))
		else $error("reset-cause flag changed by write"); // RULE_05
	a_flag_wins: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		hit_status && flag_update_in && !flag_z_only_in
		|=> st.carry_flag == $past(carry) && st.zero_flag == $past(next_z)
		&& st.digit_carry_flag == $past(dcarry))
		else $error("data write overrode flags"); // RULE_04
	a_zonly_hold: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		flag_update_in && flag_z_only_in
		|=> $stable(st.digit_carry_flag) && $stable(st.carry_flag))
		else $error("zero-only op changed carries"); // RULE_04
	a_zero_result: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		flag_update_in |=> st.zero_flag == (alu_result_out == 8'h00))
		else $error("zero flag disagrees with result"); // RULE_14
	a_bank_write: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		hit_status |=> st.direct_bank_select
		== $past(wr_in.data[`BIT_RP_HI:`BIT_RP_LO]))
		else $error("bank select not written"); // RULE_03
	a_sleep_pd: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		sleep_in |=> !st.powerdown_flag)
		else $error("sleep left power-down set"); // RULE_12
	a_timeout_clr: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		wdt_timeout_in |=> !st.timeout_flag)
		else $error("timeout did not clear flag"); // RULE_13
	a_sub_borrow: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		flag_update_in && !flag_z_only_in
		&& alu_op_in == cpu_status_pkg::ALU_SUB
		|=> st.carry_flag == ($past(alu_a_in) >= $past(alu_b_in)))
		else $error("subtract carry not inverted borrow"); // RULE_07
	a_direct_addr: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		##1 direct_addr_out[8:7] == $past(st.direct_bank_select))
		else $error("direct bank bits wrong"); // RULE_10
	a_indirect_addr: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		##1 indirect_addr_out[8] == $past(st.indirect_bank_select))
		else $error("indirect bank bit wrong"); // RULE_09
	a_pc_copy: assert property (@(posedge core_clk_in)
		disable iff (!rst_b_in)
		hit_pchi ##1 pc_load_in && !hit_pchi |=> pc_high_out == $past(
		wr_in.data[PCHI_W-1:0], 2))
		else $error("latch not copied to pc"); // RULE_01
	c_sleep: cover property (@(posedge core_clk_in) sleep_in);
	c_status_wr: cover property (@(posedge core_clk_in)
		hit_status && flag_update_in);
	c_sub: cover property (@(posedge core_clk_in)
		alu_op_in == cpu_status_pkg::ALU_SUB && flag_update_in);
	c_jump: cover property (@(posedge core_clk_in) hit_pchi ##1 pc_load_in);
endmodule
`default_nettype wire

// ==== testbench/exec_datapath_model.sv ====
/*
 Execution datapath model: drives destination writes, ALU work and
 sleep/watchdog events into the status block, one request per cycle.
 Assumes tasks are entered just after a falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module exec_datapath_model (
	input wire logic clk_in, // Core clock
	output cpu_status_pkg::file_write_t wr_out, // Destination write
	output logic [6:0] rd_offset_out, // Read offset
	output logic [7:0] fsr_out, // Indirect pointer
	output cpu_status_pkg::alu_op_t op_out, // Operation class
	output logic [7:0] a_out, // First operand
	output logic [7:0] b_out, // Second operand
	output logic upd_out, // Flags updated
	output logic zonly_out, // Zero flag only
	output logic [3:0] ev_out // {load, timeout, wdt clear, sleep}
);
	initial begin
		wr_out = '0;
		rd_offset_out = 7'h00;
		fsr_out = 8'h00;
		op_out = cpu_status_pkg::ALU_PASS;
		a_out = 8'h00;
		b_out = 8'h00;
		upd_out = 1'b0;
		zonly_out = 1'b0;
		ev_out = 4'h0;
	end
	// ==========================================================
	// One instruction: held across one rising edge, then dropped, then
	// one idle edge so a following call never re-drives in the same step
	// Status changes are whole-byte moves, never read-modify-write
	task automatic cycle(input logic v, i, input logic [6:0] o,
		input logic [7:0] d, input cpu_status_pkg::alu_op_t op,
		input logic [7:0] a, b, input logic u, z, input logic [3:0] e);
		wr_out = '{v, i, o, d};
		op_out = op;
		a_out = a;
		b_out = b;
		upd_out = u;
		zonly_out = z;
		ev_out = e;
		@(posedge clk_in);
		@(negedge clk_in);
		wr_out.valid = 1'b0;
		upd_out = 1'b0;
		zonly_out = 1'b0;
		ev_out = 4'h0;
		@(posedge clk_in);
		@(negedge clk_in);
	endtask
	// Latch write, then a jump on the very next edge
	task automatic write_jump(input logic [6:0] o, input logic [7:0] d);
		wr_out = '{1'b1, 1'b0, o, d};
		@(posedge clk_in);
		@(negedge clk_in);
		wr_out.valid = 1'b0;
		ev_out = 4'h8;
		@(posedge clk_in);
		@(negedge clk_in);
		ev_out = 4'h0;
		@(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic point(input logic [6:0] o, input logic [7:0] f);
		rd_offset_out = o;
		fsr_out = f;
		@(posedge clk_in);
		@(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
 Self-checking bench for the status register block.
 Assumes the datapath model is the only driver of the block's inputs other than clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	cpu_status_pkg::file_write_t wr;
	cpu_status_pkg::alu_op_t op;
	cpu_status_pkg::status_t st;
	logic [7:0] fsr, a, b, rd, res;
	logic [6:0] off;
	logic [8:0] dadr, iadr;
	logic [4:0] pch;
	logic [3:0] ev;
	logic upd, zo;
	int fails = 0;
	int compares = 0;
	always #2 core_clk_in = ~core_clk_in;
	exec_datapath_model pm_u (.clk_in(core_clk_in), .wr_out(wr),
		.rd_offset_out(off), .fsr_out(fsr), .op_out(op), .a_out(a),
		.b_out(b), .upd_out(upd), .zonly_out(zo), .ev_out(ev));
	cpu_status_bank_select dut_u (.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in), .wr_in(wr), .rd_offset_in(off),
		.fsr_in(fsr), .alu_op_in(op), .alu_a_in(a), .alu_b_in(b),
		.flag_update_in(upd), .flag_z_only_in(zo), .sleep_in(ev[0]),
		.wdt_clear_in(ev[1]), .wdt_timeout_in(ev[2]),
		.pc_load_in(ev[3]), .status_out(st), .rd_data_out(rd),
		.alu_result_out(res), .direct_addr_out(dadr),
		.indirect_addr_out(iadr), .pc_high_out(pch));
	task automatic check(input logic [8:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// Result, zero, digit carry, carry; on subtract carries mean no borrow
	function automatic logic [10:0] alu_exp(input logic s,
		input logic [7:0] x, y);
		logic [7:0] r;
		logic z, dc, c;
		if (s) begin
			r = x - y;
			dc = x[3:0] >= y[3:0];
			c = x >= y;
		end else begin
			r = x + y;
			dc = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
			c = ({1'b0, x} + {1'b0, y}) > 9'h0ff;
		end
		z = r == 8'h00;
		return {r, z, dc, c};
	endfunction
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check(st, 9'h018, "reset status");
		check(res, 9'h000, "reset result");
		check(pch, 9'h000, "reset pc");
		check(rd, 9'h000, "reset read");
		check(dadr, 9'h000, "reset direct");
		check(iadr, 9'h000, "reset indirect");
		$display("reset test done");
	endtask
	task automatic t_write;
		pm_u.cycle(1, 0, 7'h03, 8'h67, op, 0, 0, 0, 0, 0);
		check(st, 9'h07f, "status write");
		pm_u.point(7'h03, 8'h83);
		pm_u.cycle(1, 1, 7'h55, 8'h80, op, 0, 0, 0, 0, 0);
		pm_u.point(7'h03, 8'h83);
		check(st, 9'h098, "indirect write");
		check(rd, 9'h098, "status read");
		check(iadr, 9'h183, "indirect high");
		pm_u.point(7'h13, 8'h00);
		check(rd, 9'h000, "unmapped read");
		$display("write test done");
	endtask
	task automatic t_banks;
		for (int r = 0; r < 4; r++) begin
			pm_u.cycle(1, 0, 7'h03, {r[0], r[1:0], 5'h00}, op, 0, 0, 0, 0, 0);
			pm_u.point(7'h25, 8'h4c);
			check(dadr, {r[1:0], 7'h25}, "direct bank");
			check(iadr, {r[0], 8'h4c}, "indirect bank");
		end
		$display("bank test done");
	endtask
	task automatic t_alu;
		logic [7:0] xa[5] = '{8'h05, 8'h03, 8'hff, 8'h10, 8'h07};
		logic [7:0] xb[5] = '{8'h03, 8'h05, 8'h01, 8'h01, 8'h07};
		logic [10:0] e;
		for (int k = 0; k < 5; k++) begin
			e = alu_exp(k != 2, xa[k], xb[k]);
			pm_u.cycle(0, 0, 0, 0, (k == 2) ? cpu_status_pkg::ALU_ADD :
				cpu_status_pkg::ALU_SUB, xa[k], xb[k], 1, 0, 0);
			check(res, e[10:3], "alu result");
			check(st[2:0], e[2:0], "alu flags");
		end
		pm_u.cycle(0, 0, 0, 0, cpu_status_pkg::ALU_LOGIC, 8'hf0,
			8'hff, 1, 1, 0);
		check(res, 9'h0f0, "logic result");
		check(st[2:0], {1'b0, e[1:0]}, "zero only");
		pm_u.cycle(0, 0, 0, 0, cpu_status_pkg::ALU_PASS, 8'h00,
			8'h5a, 1, 1, 0);
		check(res, 9'h000, "pass result");
		check(st[2:0], {1'b1, e[1:0]}, "pass zero");
		$display("alu test done");
	endtask
	task automatic t_clash;
		pm_u.cycle(1, 0, 7'h03, 8'he7, cpu_status_pkg::ALU_ADD, 8'h01,
			8'h01, 1, 0, 0);
		check(st, 9'h0f8, "flags beat data");
		pm_u.cycle(1, 0, 7'h03, 8'h03, cpu_status_pkg::ALU_LOGIC,
			8'h0f, 8'hf0, 1, 1, 0);
		check(st, 9'h01c, "zero beats data");
		$display("clash test done");
	endtask
	task automatic t_events;
		logic [3:0] e[5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h3};
		logic [1:0] x[5] = '{2'b10, 2'b11, 2'b01, 2'b01, 2'b10};
		for (int k = 0; k < 5; k++) begin
			pm_u.cycle(0, 0, 0, 0, op, 0, 0, 0, 0, e[k]);
			check(st[4:3], x[k], "reset cause");
		end
		pm_u.cycle(1, 0, 7'h03, 8'h08, op, 0, 0, 0, 0, 0);
		check(st[4:3], 2'b10, "cause flags ignore write");
		$display("event test done");
	endtask
	task automatic t_latch;
		pm_u.cycle(1, 0, 7'h0a, 8'h1f, op, 0, 0, 0, 0, 0);
		check(pch, 9'h000, "no direct pc");
		pm_u.point(7'h0a, 8'h00);
		check(rd, 9'h01f, "latch read");
		pm_u.cycle(1, 0, 7'h0a, 8'h05, op, 0, 0, 0, 0, 4'h8);
		check(pch, 9'h01f, "pc copy");
		pm_u.cycle(0, 0, 0, 0, op, 0, 0, 0, 0, 0);
		check(pch, 9'h01f, "pc holds");
		pm_u.cycle(0, 0, 0, 0, op, 0, 0, 0, 0, 4'h8);
		check(pch, 9'h005, "pc second copy");
		pm_u.write_jump(7'h0a, 8'h0c);
		check(pch, 9'h00c, "write then jump");
		$display("latch test done");
	endtask
	task automatic t_rerun;
		rst_b_in = 1'b0;
		@(posedge core_clk_in);
		@(negedge core_clk_in);
		check(st, 9'h018, "mid-run reset status");
		check(pch, 9'h000, "mid-run reset pc");
		rst_b_in = 1'b1;
		@(posedge core_clk_in);
		@(negedge core_clk_in);
		check(st, 9'h018, "status after release");
		$display("rerun test done");
	endtask
	task automatic complete_run;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk_in);
		@(negedge core_clk_in);
		t_reset();
		rst_b_in = 1'b1;
		t_write();
		t_banks();
		t_alu();
		t_clash();
		t_events();
		t_latch();
		t_rerun();
		complete_run();
	end
	// The tests take well under 200 cycles
	initial begin
		#4000;
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire
